// [ebwh_ctrl.sv]
`timescale 1ns/1ns
module ebwh_ctrl (
  // Clock and reset
  input  wire  logic                 core_clk,
  input  wire  logic                 reset,
  // Configuration writes
  input  wire  logic                 pm0_wr,
  input  wire  logic                 pm1_wr,
  input  wire  logic                 csc_wr,
  input  wire  logic [7:0]           cfg_wdata,
  input  wire  logic [7:0]           protect_reg,
  input  wire  logic                 microproc_mode,
  input  wire  logic [3:0]           mux_area,
  // Requesters
  input  wire  logic                 dma_valid,
  input  wire  ebwh_pkg::ebwh_req_t  dma_req,
  input  wire  logic                 cpu_valid,
  input  wire  ebwh_pkg::ebwh_req_t  cpu_req,
  output logic                       dma_done,
  output logic                       cpu_done,
  output logic [15:0]                rd_data,
  // Configuration readback
  output logic [7:0]                 pm0_q,
  output logic [7:0]                 pm1_q,
  output logic [7:0]                 csc_q,
  // Pins
  input  wire  logic [15:0]          data_i,
  input  wire  logic                 bus_hold_req_n,
  input  wire  logic                 wait_req_n,
  output ebwh_pkg::ebwh_pins_t       pins
);

  // ****************************************
  // Types and functions
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_HOLD} ebwh_state_t;

  function automatic ebwh_pkg::ebwh_area_t area_of(input logic [19:0] a, input logic mp);
    if (a <= ebwh_pkg::SFR_END) begin
      area_of = ebwh_pkg::EA_SFR;
    end else if (a < ebwh_pkg::CS3_BASE || (!mp && a >= ebwh_pkg::INT_ROM_BASE)) begin
      area_of = ebwh_pkg::EA_INT;
    end else if (a < ebwh_pkg::CS2_BASE) begin
      area_of = ebwh_pkg::EA_CS3;
    end else if (a < ebwh_pkg::CS1_BASE) begin
      area_of = ebwh_pkg::EA_CS2;
    end else if (a < ebwh_pkg::CS0_BASE) begin
      area_of = ebwh_pkg::EA_CS1;
    end else begin
      area_of = ebwh_pkg::EA_CS0;
    end
  endfunction

  function automatic logic [1:0] cs_idx(input ebwh_pkg::ebwh_area_t ar);
    cs_idx = 2'(ar - ebwh_pkg::EA_CS0);
  endfunction

  // The multiplexed bus is forced to wait so a zero area bit is never needed there.
  function automatic logic [1:0] cyc_len(input ebwh_pkg::ebwh_area_t ar, input logic gw,
                                         input logic [3:0] fast, input logic [3:0] mux);
    case (ar)
      ebwh_pkg::EA_SFR: cyc_len = ebwh_pkg::LEN_SFR;
      ebwh_pkg::EA_INT: cyc_len = gw ? ebwh_pkg::LEN_SEP_WAIT : ebwh_pkg::LEN_FAST;
      default: begin
        if (mux[cs_idx(ar)]) begin
          cyc_len = ebwh_pkg::LEN_MUX_WAIT;
        end else if (gw || !fast[cs_idx(ar)]) begin
          cyc_len = ebwh_pkg::LEN_SEP_WAIT;
        end else begin
          cyc_len = ebwh_pkg::LEN_FAST;
        end
      end
    endcase
  endfunction

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  logic [2:0] hold_s_r, hold_s_nxt, wait_s_r, wait_s_nxt;
  logic       hold_lvl_r, hold_lvl_nxt, wait_lvl_r, wait_lvl_nxt;

  always_comb begin
    hold_s_nxt   = {hold_s_r[1:0], bus_hold_req_n};
    wait_s_nxt   = {wait_s_r[1:0], wait_req_n};
    hold_lvl_nxt = (hold_s_r[1] == hold_s_r[2]) ? hold_s_r[2] : hold_lvl_r;
    wait_lvl_nxt = (wait_s_r[1] == wait_s_r[2]) ? wait_s_r[2] : wait_lvl_r;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_s_r   <= 3'h7;
      wait_s_r   <= 3'h7;
      hold_lvl_r <= 1'b1;
      wait_lvl_r <= 1'b1;
    end else begin
      hold_s_r   <= hold_s_nxt;
      wait_s_r   <= wait_s_nxt;
      hold_lvl_r <= hold_lvl_nxt;
      wait_lvl_r <= wait_lvl_nxt;
    end
  end

  // ****************************************
  // Mode and chip select registers
  // ****************************************
  logic [7:0] pm0_r, pm0_nxt, pm1_r, pm1_nxt, csc_r, csc_nxt;
  logic       prot_ok;

  assign prot_ok = protect_reg[ebwh_pkg::PROT_PM_BIT];

  always_comb begin
    pm0_nxt = (pm0_wr && prot_ok) ? cfg_wdata : pm0_r;
    pm1_nxt = (pm1_wr && prot_ok) ? cfg_wdata : pm1_r;
    csc_nxt = csc_wr ? cfg_wdata : csc_r;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pm0_r <= ebwh_pkg::PM0_RST;
      pm1_r <= ebwh_pkg::PM1_RST;
      csc_r <= ebwh_pkg::CSC_RST;
    end else begin
      pm0_r <= pm0_nxt;
      pm1_r <= pm1_nxt;
      csc_r <= csc_nxt;
    end
  end

  assign pm0_q = pm0_r;
  assign pm1_q = pm1_r;
  assign csc_q = csc_r;

  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  ebwh_state_t          st_r, st_nxt;
  logic [1:0]           cnt_r, cnt_nxt, len_r, len_nxt;
  ebwh_pkg::ebwh_req_t  cur_r, cur_nxt;
  ebwh_pkg::ebwh_area_t area_r, area_nxt;
  logic                 own_dma_r, own_dma_nxt, rdy_use_r, rdy_use_nxt;
  logic                 start_r, start_nxt, dma_done_r, dma_done_nxt, cpu_done_r, cpu_done_nxt;
  logic [15:0]          rdata_r, rdata_nxt;
  ebwh_pkg::ebwh_pins_t pins_r, pins_nxt;
  logic [3:0]           cs_fast;
  logic                 gwait, sep_strobe;

  assign cs_fast    = csc_r[ebwh_pkg::CSC_FAST_LSB +: 4];
  assign gwait      = pm1_r[ebwh_pkg::PM1_WAIT_BIT];
  assign sep_strobe = pm0_r[ebwh_pkg::PM0_STROBE_BIT];

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    len_nxt      = len_r;
    cur_nxt      = cur_r;
    area_nxt     = area_r;
    own_dma_nxt  = own_dma_r;
    rdy_use_nxt  = rdy_use_r;
    start_nxt    = 1'b0;
    dma_done_nxt = 1'b0;
    cpu_done_nxt = 1'b0;
    rdata_nxt    = rdata_r;
    pins_nxt     = pins_r;
    pins_nxt.bclk    = ~pins_r.bclk;
    pins_nxt.bclk_oe = ~pm0_r[ebwh_pkg::PM0_BCLK_OFF_BIT];
    case (st_r)
      ST_IDLE: begin
        if (!hold_lvl_r) begin
          st_nxt = ST_HOLD;
          pins_nxt.addr_oe           = 1'b0;
          pins_nxt.data_oe           = 1'b0;
          pins_nxt.strobe_oe         = 1'b0;
          pins_nxt.cs_oe             = 1'b0;
          pins_nxt.bus_grant_ack_n   = 1'b0;
          pins_nxt.shared_port_float = 1'b1;
          pins_nxt.port_freeze       = 1'b1;
          pins_nxt.wdt_pause         = 1'b1;
        end else if (dma_valid || cpu_valid) begin
          st_nxt      = ST_ACC;
          start_nxt   = 1'b1;
          own_dma_nxt = dma_valid;
          cur_nxt     = dma_valid ? dma_req : cpu_req;
          area_nxt    = area_of(cur_nxt.addr, microproc_mode);
          len_nxt     = cyc_len(area_nxt, gwait, cs_fast, mux_area);
          cnt_nxt     = len_nxt;
          rdy_use_nxt = (area_nxt >= ebwh_pkg::EA_CS0) && !cs_fast[cs_idx(area_nxt)];
          if (area_nxt != ebwh_pkg::EA_INT) begin
            pins_nxt.addr    = cur_nxt.addr;
            pins_nxt.data    = cur_nxt.wdata;
            pins_nxt.data_oe = cur_nxt.wr;
            pins_nxt.rd_n    = cur_nxt.wr;
            pins_nxt.upper_byte_enable_n = !(cur_nxt.word || cur_nxt.addr[0]);
            if (sep_strobe) begin
              pins_nxt.low_byte_write_n  = !(cur_nxt.wr && (cur_nxt.word || !cur_nxt.addr[0]));
              pins_nxt.high_byte_write_n = !(cur_nxt.wr && (cur_nxt.word || cur_nxt.addr[0]));
            end else begin
              pins_nxt.low_byte_write_n  = !cur_nxt.wr;
              pins_nxt.high_byte_write_n = 1'b1;
            end
          end
          if (area_nxt >= ebwh_pkg::EA_CS0) begin
            pins_nxt.area_select_n = ~(4'h1 << cs_idx(area_nxt));
            pins_nxt.ale           = mux_area[cs_idx(area_nxt)];
          end
        end
      end
      ST_ACC: begin
        pins_nxt.ale = 1'b0;
        if (cnt_r == 2'h1 && !(rdy_use_r && !wait_lvl_r)) begin
          st_nxt       = ST_IDLE;
          dma_done_nxt = own_dma_r;
          cpu_done_nxt = !own_dma_r;
          rdata_nxt    = data_i;
          pins_nxt.rd_n              = 1'b1;
          pins_nxt.low_byte_write_n  = 1'b1;
          pins_nxt.high_byte_write_n = 1'b1;
          pins_nxt.area_select_n     = 4'hF;
          pins_nxt.data_oe           = 1'b0;
        end else if (cnt_r > 2'h1) begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      default: begin
        if (hold_lvl_r) begin
          st_nxt = ST_IDLE;
          pins_nxt.addr_oe           = 1'b1;
          pins_nxt.strobe_oe         = 1'b1;
          pins_nxt.cs_oe             = 1'b1;
          pins_nxt.bus_grant_ack_n   = 1'b1;
          pins_nxt.shared_port_float = 1'b0;
          pins_nxt.port_freeze       = 1'b0;
          pins_nxt.wdt_pause         = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r       <= ST_IDLE;
      cnt_r      <= 2'h0;
      len_r      <= 2'h0;
      cur_r      <= '0;
      area_r     <= ebwh_pkg::EA_INT;
      own_dma_r  <= 1'b0;
      rdy_use_r  <= 1'b0;
      start_r    <= 1'b0;
      dma_done_r <= 1'b0;
      cpu_done_r <= 1'b0;
      rdata_r    <= 16'h0000;
      pins_r     <= '{addr: 20'h00000, data: 16'h0000, area_select_n: 4'hF, rd_n: 1'b1,
                      low_byte_write_n: 1'b1, high_byte_write_n: 1'b1,
                      upper_byte_enable_n: 1'b1, addr_oe: 1'b1, strobe_oe: 1'b1,
                      cs_oe: 1'b1, bus_grant_ack_n: 1'b1, bclk_oe: 1'b1, default: 1'b0};
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      len_r      <= len_nxt;
      cur_r      <= cur_nxt;
      area_r     <= area_nxt;
      own_dma_r  <= own_dma_nxt;
      rdy_use_r  <= rdy_use_nxt;
      start_r    <= start_nxt;
      dma_done_r <= dma_done_nxt;
      cpu_done_r <= cpu_done_nxt;
      rdata_r    <= rdata_nxt;
      pins_r     <= pins_nxt;
    end
  end

  assign pins     = pins_r;
  assign dma_done = dma_done_r;
  assign cpu_done = cpu_done_r;
  assign rd_data  = rdata_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_hold_taken;
    st_r == ST_IDLE && !hold_lvl_r;
  endsequence

  sequence s_int_start;
    start_r && area_r == ebwh_pkg::EA_INT;
  endsequence

  a_hold_grant: assert property (s_hold_taken |=> !pins_r.bus_grant_ack_n && st_r == ST_HOLD)
    else $error("Hold not granted after idle");
  a_grant_order: assert property (st_r == ST_IDLE && hold_lvl_r && dma_valid |=> start_r && own_dma_r)
    else $error("DMA did not win over the core");
  a_hold_float: assert property (!pins_r.bus_grant_ack_n |-> !pins_r.addr_oe && !pins_r.data_oe
                                 && !pins_r.strobe_oe && !pins_r.cs_oe)
    else $error("Bus driven during hold");
  a_hold_ports: assert property (!pins_r.bus_grant_ack_n |-> pins_r.shared_port_float
                                 && pins_r.port_freeze && pins_r.wdt_pause)
    else $error("Ports or watchdog wrong during hold");
  a_int_pins: assert property (s_int_start |-> pins_r.rd_n && pins_r.low_byte_write_n
                               && pins_r.area_select_n == 4'hF && !pins_r.ale
                               && $stable(pins_r.addr) && $stable(pins_r.upper_byte_enable_n))
    else $error("Internal access disturbed the bus");
  a_sfr_len: assert property (start_r && area_r == ebwh_pkg::EA_SFR |-> !pins_r.rd_n
                              || !pins_r.low_byte_write_n ##1 !dma_done_r && !cpu_done_r
                              ##1 dma_done_r || cpu_done_r)
    else $error("Special area access not two cycles");
  a_int_fast: assert property ((s_int_start and !gwait) |=> dma_done_r || cpu_done_r)
    else $error("Internal access not one cycle");
  a_int_wait: assert property ((s_int_start and gwait) |=> !(dma_done_r || cpu_done_r)
                               ##1 (dma_done_r || cpu_done_r))
    else $error("Waited internal access not two cycles");
  a_mux_len: assert property (start_r && area_r >= ebwh_pkg::EA_CS0 && mux_area[cs_idx(area_r)]
                              |-> len_r == ebwh_pkg::LEN_MUX_WAIT && pins_r.ale)
    else $error("Multiplexed cycle length wrong");
  a_area_fast: assert property (start_r && area_r >= ebwh_pkg::EA_CS0 && !gwait
                                && !mux_area[cs_idx(area_r)] && cs_fast[cs_idx(area_r)]
                                |=> dma_done_r || cpu_done_r)
    else $error("Fast area not one cycle");
  a_protect: assert property (!$past(prot_ok) |-> $stable(pm0_r) && $stable(pm1_r))
    else $error("Mode register changed without protect");
  a_reset_wait: assert property ($past(reset) |-> !gwait && cs_fast == 4'h0)
    else $error("Wait bits not cleared by reset");
  a_bclk_float: assert property ($past(pm0_r[ebwh_pkg::PM0_BCLK_OFF_BIT]) |-> !pins_r.bclk_oe)
    else $error("Bus clock pin driven while disabled");

endmodule

// [ebwh_ext_model.sv]
`timescale 1ns/1ns
// ****************************************
// Far side: memory, ready source and outside bus master
// ****************************************
module ebwh_ext_model (
  // Clock
  input  wire  logic                  core_clk,
  // Bench controls
  input  wire  logic                  hold_want,
  input  wire  logic                  stall,
  // Pins
  input  wire  ebwh_pkg::ebwh_pins_t  pins,
  output logic [15:0]                 data_i,
  output logic                        bus_hold_req_n,
  output logic                        wait_req_n
);
  // A released data bus changes every cycle so stale data is never mistaken for a read.
  logic [15:0] float_r = 16'h3C96;

  always_ff @(posedge core_clk) begin
    float_r <= ~float_r;
  end

  always_comb begin
    if (pins.strobe_oe && !pins.rd_n) begin
      data_i = pins.addr[15:0] ^ 16'h5A5A;
    end else begin
      data_i = float_r;
    end
  end

  assign bus_hold_req_n = ~hold_want;
  assign wait_req_n     = ~stall;
endmodule

// [ebwh_pkg.sv]
package ebwh_pkg;

  // ****************************************
  // Bus cycle lengths in core_clk cycles
  // ****************************************
  localparam logic [1:0] LEN_FAST     = 2'h1;
  localparam logic [1:0] LEN_SEP_WAIT = 2'h2;
  localparam logic [1:0] LEN_MUX_WAIT = 2'h3;
  localparam logic [1:0] LEN_SFR      = 2'h2;

  // ****************************************
  // Register bit positions and reset values
  // ****************************************
  localparam int PM0_STROBE_BIT   = 2;
  localparam int PM0_BCLK_OFF_BIT = 7;
  localparam int PM1_WAIT_BIT     = 7;
  localparam int PROT_PM_BIT      = 1;
  localparam int CSC_FAST_LSB     = 4;
  localparam logic [7:0] PM0_RST  = 8'h00;
  localparam logic [7:0] PM1_RST  = 8'h00;
  localparam logic [7:0] CSC_RST  = 8'h01;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [19:0] SFR_END      = 20'h003FF;
  localparam logic [19:0] CS3_BASE     = 20'h04000;
  localparam logic [19:0] CS2_BASE     = 20'h08000;
  localparam logic [19:0] CS1_BASE     = 20'h28000;
  localparam logic [19:0] CS0_BASE     = 20'h30000;
  localparam logic [19:0] INT_ROM_BASE = 20'hF0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {EA_SFR, EA_INT, EA_CS0, EA_CS1, EA_CS2, EA_CS3} ebwh_area_t;

  typedef struct packed {
    logic [19:0] addr;
    logic        wr;
    logic        word;
    logic [15:0] wdata;
  } ebwh_req_t;

  typedef struct packed {
    logic [19:0] addr;
    logic        addr_oe;
    logic [15:0] data;
    logic        data_oe;
    logic        rd_n;
    logic        low_byte_write_n;
    logic        high_byte_write_n;
    logic        upper_byte_enable_n;
    logic        strobe_oe;
    logic [3:0]  area_select_n;
    logic        cs_oe;
    logic        ale;
    logic        bus_grant_ack_n;
    logic        bclk;
    logic        bclk_oe;
    logic        shared_port_float;
    logic        port_freeze;
    logic        wdt_pause;
  } ebwh_pins_t;

endpackage

// [external_bus_wait_hold_control_test.sv]
`timescale 1ns/1ns
module external_bus_wait_hold_control_test;
  // ****************************************
  // Signals
  // ****************************************
  logic                 core_clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 pm0_wr = 1'b0, pm1_wr = 1'b0, csc_wr = 1'b0;
  logic [7:0]           cfg_wdata = 8'h00;
  logic [7:0]           protect_reg = 8'h00;
  logic [3:0]           mux_area = 4'h0;
  logic                 dma_valid = 1'b0, cpu_valid = 1'b0;
  ebwh_pkg::ebwh_req_t  dma_req = '0, cpu_req = '0;
  logic                 dma_done, cpu_done;
  logic [15:0]          rd_data, data_i;
  logic [7:0]           pm0_q, pm1_q, csc_q;
  logic                 bus_hold_req_n, wait_req_n;
  logic                 hold_want = 1'b0, stall = 1'b0;
  ebwh_pkg::ebwh_pins_t pins;
  int                   err_count = 0;
  int                   n_tests = 0;
  logic [19:0]          abase [4];

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  ebwh_ctrl ebwh_ctrl_inst (.core_clk(core_clk), .reset(reset), .pm0_wr(pm0_wr),
    .pm1_wr(pm1_wr), .csc_wr(csc_wr), .cfg_wdata(cfg_wdata), .protect_reg(protect_reg),
    .microproc_mode(1'b0), .mux_area(mux_area), .dma_valid(dma_valid), .dma_req(dma_req),
    .cpu_valid(cpu_valid), .cpu_req(cpu_req), .dma_done(dma_done), .cpu_done(cpu_done),
    .rd_data(rd_data), .pm0_q(pm0_q), .pm1_q(pm1_q), .csc_q(csc_q), .data_i(data_i),
    .bus_hold_req_n(bus_hold_req_n), .wait_req_n(wait_req_n), .pins(pins));

  ebwh_ext_model ebwh_ext_model_inst (.core_clk(core_clk), .hold_want(hold_want),
    .stall(stall), .pins(pins), .data_i(data_i), .bus_hold_req_n(bus_hold_req_n),
    .wait_req_n(wait_req_n));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cfg(input int sel, input logic [7:0] d);
    pm0_wr = (sel == 0);
    pm1_wr = (sel == 1);
    csc_wr = (sel == 2);
    cfg_wdata = d;
    @(negedge core_clk);
    {pm0_wr, pm1_wr, csc_wr} = 3'b000;
    @(negedge core_clk);
  endtask

  // Core word read; length counted in falling edges until done, done lands at L+1.
  task automatic run(input logic [19:0] a, input int len, input logic [3:0] sel, input bit st);
    int   n;
    logic [3:0] seen;
    logic rds;
    n = 0;
    seen = 4'hF;
    rds = 1'b0;
    cpu_req = '{addr: a, wr: 1'b0, word: 1'b1, wdata: 16'h0000};
    cpu_valid = 1'b1;
    while (n < 20) begin
      @(negedge core_clk);
      n++;
      seen &= pins.area_select_n;
      if (pins.strobe_oe === 1'b1 && pins.rd_n === 1'b0) rds = 1'b1;
      if (cpu_done === 1'b1) break;
    end
    cpu_valid = 1'b0;
    check("cycles", 32'(n), 32'(len + 1));
    check("selects", {28'h0, seen}, {28'h0, sel});
    check("strobe", {31'h0, rds}, {31'h0, st});
    if (st) check("rd_data", {16'h0, rd_data}, {16'h0, a[15:0] ^ 16'h5A5A});
  endtask

  task automatic wait_done(output bit got);
    got = 1'b0;
    repeat (12) begin
      @(negedge core_clk);
      if (cpu_done === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
    cpu_valid = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check("pm0", {24'h0, pm0_q}, 32'h00);
    check("pm1", {24'h0, pm1_q}, 32'h00);
    check("csc", {24'h0, csc_q}, {24'h0, ebwh_pkg::CSC_RST});
    check("bclk_oe", {31'h0, pins.bclk_oe}, 32'h1);
    $display("test reset finished");
  endtask

  task automatic t_lengths();
    run(20'h00100, 2, 4'hF, 1);
    for (int i = 0; i < 4; i++) run(abase[i], 2, ~(4'h1 << i), 1);
    mux_area = 4'h2;
    cfg(2, 8'hF1);
    run(abase[1], 3, 4'hD, 1);
    run(abase[0], 1, 4'hE, 1);
    mux_area = 4'h0;
    for (int i = 0; i < 4; i++) begin
      cfg(2, 8'h01 | (8'h10 << i));
      run(abase[i], 1, ~(4'h1 << i), 1);
      run(abase[(i + 1) % 4], 2, ~(4'h1 << ((i + 1) % 4)), 1);
    end
    $display("test lengths finished");
  endtask

  task automatic t_ready();
    bit got;
    bit early;
    early = 1'b0;
    cfg(2, 8'h01);
    stall = 1'b1;
    repeat (4) @(negedge core_clk);
    cpu_req = '{addr: abase[2], wr: 1'b0, word: 1'b1, wdata: 16'h0000};
    cpu_valid = 1'b1;
    repeat (8) begin
      @(negedge core_clk);
      if (cpu_done === 1'b1) early = 1'b1;
    end
    check("ready early", {31'h0, early}, 32'h0);
    check("ready rd_n", {31'h0, pins.rd_n}, 32'h0);
    stall = 1'b0;
    wait_done(got);
    check("ready done", {31'h0, got}, 32'h1);
    $display("test ready finished");
  endtask

  task automatic t_hold();
    bit   got;
    logic b;
    hold_want = 1'b1;
    repeat (10) begin
      @(negedge core_clk);
      if (pins.bus_grant_ack_n === 1'b0) break;
    end
    check("ack", {31'h0, pins.bus_grant_ack_n}, 32'h0);
    check("oes", {28'h0, pins.addr_oe, pins.data_oe, pins.strobe_oe, pins.cs_oe}, 32'h0);
    check("ports", {30'h0, pins.shared_port_float, pins.port_freeze}, 32'h3);
    check("wdt", {31'h0, pins.wdt_pause}, 32'h1);
    check("ale", {31'h0, pins.ale}, 32'h0);
    b = pins.bclk;
    cpu_req = '{addr: 20'h00800, wr: 1'b0, word: 1'b1, wdata: 16'h0000};
    cpu_valid = 1'b1;
    @(negedge core_clk);
    check("bclk runs", {31'h0, pins.bclk}, {31'h0, ~b});
    got = 1'b0;
    repeat (6) begin
      @(negedge core_clk);
      if (cpu_done === 1'b1) got = 1'b1;
    end
    check("held off", {31'h0, got}, 32'h0);
    hold_want = 1'b0;
    wait_done(got);
    check("after hold", {31'h0, got}, 32'h1);
    check("ack off", {31'h0, pins.bus_grant_ack_n}, 32'h1);
    $display("test hold finished");
  endtask

  task automatic t_hold_mid();
    bit early;
    bit fin;
    early = 1'b0;
    fin = 1'b0;
    cpu_req = '{addr: abase[2], wr: 1'b0, word: 1'b1, wdata: 16'h0000};
    cpu_valid = 1'b1;
    @(negedge core_clk);
    hold_want = 1'b1;
    repeat (12) begin
      @(negedge core_clk);
      if (pins.bus_grant_ack_n === 1'b0 && !fin) early = 1'b1;
      if (cpu_done === 1'b1) begin
        fin = 1'b1;
        cpu_valid = 1'b0;
      end
      if (fin && pins.bus_grant_ack_n === 1'b0) break;
    end
    check("mid early", {31'h0, early}, 32'h0);
    check("mid ack", {30'h0, fin, pins.bus_grant_ack_n}, 32'h2);
    hold_want = 1'b0;
    repeat (6) @(negedge core_clk);
    $display("test hold in access finished");
  endtask

  task automatic t_priority();
    bit got;
    dma_req = '{addr: 20'h00100, wr: 1'b0, word: 1'b1, wdata: 16'h0000};
    cpu_req = '{addr: 20'h00800, wr: 1'b0, word: 1'b1, wdata: 16'h0000};
    {dma_valid, cpu_valid} = 2'b11;
    repeat (12) begin
      @(negedge core_clk);
      if (dma_done === 1'b1 || cpu_done === 1'b1) break;
    end
    check("first done", {30'h0, dma_done, cpu_done}, 32'h2);
    dma_valid = 1'b0;
    wait_done(got);
    check("core next", {31'h0, got}, 32'h1);
    $display("test priority finished");
  endtask

  task automatic t_internal();
    logic [19:0] a;
    logic        u;
    run(abase[2], 2, 4'hB, 1);
    a = pins.addr;
    u = pins.upper_byte_enable_n;
    run(20'h00800, 1, 4'hF, 0);
    check("addr kept", {12'h0, pins.addr}, {12'h0, a});
    check("ale low", {31'h0, pins.ale}, 32'h0);
    check("bhe kept", {31'h0, pins.upper_byte_enable_n}, {31'h0, u});
    $display("test internal finished");
  endtask

  task automatic t_global();
    cfg(2, 8'hF1);
    protect_reg = 8'h00;
    cfg(1, 8'h80);
    check("pm1 locked", {24'h0, pm1_q}, 32'h00);
    protect_reg = 8'h02;
    cfg(1, 8'h80);
    check("pm1 open", {24'h0, pm1_q}, 32'h80);
    run(20'h00800, 2, 4'hF, 0);
    run(abase[0], 2, 4'hE, 1);
    run(20'h00100, 2, 4'hF, 1);
    cfg(0, 8'h80);
    check("bclk float", {31'h0, pins.bclk_oe}, 32'h0);
    $display("test global wait finished");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    abase = '{ebwh_pkg::CS0_BASE, ebwh_pkg::CS1_BASE, ebwh_pkg::CS2_BASE, ebwh_pkg::CS3_BASE};
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_lengths();
    t_ready();
    t_hold();
    t_hold_mid();
    t_priority();
    t_internal();
    t_global();
    stop_test();
  end

  // The whole run needs well under a thousand cycles; this bound only cuts off a hang.
  initial begin
    #(5000 * 4);
    err_count++;
    stop_test();
  end
endmodule
